/* design/memlcd_params.svh */
// Named constants for the memory display panel logic.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MEMLCD_PARAMS_SVH
`define MEMLCD_PARAMS_SVH

// ============================================================
// Geometry and field positions
`define MLCD_LINES 96
`define MLCD_LINE_W 7
`define MLCD_ADDR_W 8
`define MLCD_FIRST_LINE 8'h01
`define MLCD_LAST_LINE 8'h60
`define MLCD_LAST_COL 7'h5F
`define MLCD_M0_POS 7
`define MLCD_M1_POS 6
`define MLCD_M2_POS 5

// ============================================================
// Bit counts per frame section, written as last index
`define MLCD_MODE_LAST 7'h07
`define MLCD_ADDR_LAST 7'h07
`define MLCD_DATA_LAST 7'h5F
`define MLCD_PAD_LAST 7'h07
`define MLCD_CNT_ZERO 7'h00
`define MLCD_CNT_ONE 7'h01

// ============================================================
// Levels and pin synchroniser
`define MLCD_WHITE 1'b1
`define MLCD_SYNC_W 5

`endif

/* design/memlcd_pkg.sv */
// Types shared by the memory display panel design.
// Assumes memlcd_params.svh is on the include path.
`include "memlcd_params.svh"

package memlcd_pkg;

	// Serial frame parser states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MODE,
		ST_ADDR,
		ST_DATA,
		ST_PAD,
		ST_SKIP
	} parse_t;

	// State of the panel apart from the pin, strap and arm flops, registered in one place.
	typedef struct packed {
		parse_t state;
		logic [`MLCD_LINE_W-1:0] cnt;
		logic [`MLCD_LINES-1:0] sh;
		logic [`MLCD_ADDR_W-1:0] addr;
		logic com;
		logic pix;
		logic busy;
		logic sclk_d;
		logic sel_d;
		logic tog_d;
		logic [`MLCD_LINES-1:0][`MLCD_LINES-1:0] mem;
	} panel_state_t;

endpackage : memlcd_pkg

/* design/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/10ps
`default_nettype none
`include "memlcd_params.svh"

module pin_sync #(
	parameter int WIDTH = `MLCD_SYNC_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);

	// ============================================================
	// One pair of flops per pin; only the second flop reads the first.
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_r;
		logic hold_r;
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				meta_r <= 1'b0;
				hold_r <= 1'b0;
			end else if (ce) begin
				meta_r <= pin[i];
				hold_r <= meta_r;
			end
		end
		assign level[i] = hold_r;
	end

endmodule : pin_sync

`default_nettype wire

/* design/memlcd_panel.sv */
// Memory display panel: serial receiver, pixel memory, blanking and COM control.
// Assumes host-driven pins arrive unsynchronised; read port is on MCLK.
`timescale 1ns/10ps
`default_nettype none
`include "memlcd_params.svh"

// What this block does
// - Holds a 96 by 96 image, one stored bit per pixel.
// - A line write changes only the addressed line.
// - Content and control arrive over serial clock, data and active-high select.
// - Strap high: COM polarity follows the external toggle input.
// - Strap low: COM follows the serial flag; toggle input ignored.
// - External toggle: with strap high and display on, each rising edge inverts COM.
// - Display on shows the stored image.
// - Display off shows white and keeps memory.
// - Display on/off never changes stored pixels.
// - Display off: no COM inversion, whatever the toggle does.
// - Mode flag high rewrites memory, low keeps it unless the clear flag is high.
// - Frame invert flag sets COM level, only with strap low and display on.
// - Mode low with clear flag high clears memory to white.
module memlcd_panel (
	// Clock, reset, enable
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic CE,
	// Serial link pins
	input wire logic SCLK,
	input wire logic SI,
	input wire logic SERIAL_SELECT_IN,
	// Control pins
	input wire logic EXT_INVERSION_TOGGLE,
	input wire logic DISPLAY_ON_OFF,
	input wire logic INVERSION_SOURCE_STRAP,
	// Pixel view port
	input wire logic [`MLCD_LINE_W-1:0] PIX_LINE,
	input wire logic [`MLCD_LINE_W-1:0] PIX_COL,
	// Panel outputs
	output logic PIXEL_SHOWN,
	output logic COMMON_ELECTRODE_LEVEL,
	output logic FRAME_ACTIVE
);
	import memlcd_pkg::*;

	localparam logic [`MLCD_LINES*`MLCD_LINES-1:0] ALL_WHITE = {(`MLCD_LINES*`MLCD_LINES){`MLCD_WHITE}};

	// ============================================================
	// Pin synchronisers
	logic [`MLCD_SYNC_W-1:0] pins_s;
	logic sclk_s, si_s, sel_s, tog_s, display_on_off_s, strap_s;
	logic strap_r;

	pin_sync #(.WIDTH(`MLCD_SYNC_W)) u_sync (
		.clk(MCLK),
		.arst_n(ARST_N),
		.ce(CE),
		.pin({SCLK, SI, SERIAL_SELECT_IN, EXT_INVERSION_TOGGLE, DISPLAY_ON_OFF}),
		.level(pins_s)
	);
	assign {sclk_s, si_s, sel_s, tog_s, display_on_off_s} = pins_s;

	// The strap is static, so it is caught by clocked flops after reset release.
	// The arm chain opens toggle edge detection only once the pin history is real,
	// so a toggle pin that is already high at reset release is not taken as a rise.
	logic strap_m;
	logic [2:0] arm_r;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			strap_m <= 1'b0;
			strap_r <= 1'b0;
			arm_r <= 3'h0;
		end else if (CE) begin
			strap_m <= INVERSION_SOURCE_STRAP;
			strap_r <= strap_m;
			arm_r <= {arm_r[1:0], 1'b1};
		end
	end
	assign strap_s = strap_r;

	// ============================================================
	// Next-state logic
	panel_state_t st_r;
	panel_state_t st_nxt;
	logic bit_in, mode_done, line_write, clear_go, tog_rise;
	logic [`MLCD_LINES-1:0] sh_new;
	logic [`MLCD_LINE_W-1:0] wr_idx;

	assign bit_in = sclk_s && !st_r.sclk_d && sel_s;
	assign sh_new = {st_r.sh[`MLCD_LINES-2:0], si_s};
	// A rise counts only after the synchroniser and the delay flop hold pin values.
	assign tog_rise = tog_s && !st_r.tog_d && arm_r[2];
	assign mode_done = bit_in && st_r.state == ST_MODE && st_r.cnt == `MLCD_MODE_LAST;
	assign clear_go = mode_done && !sh_new[`MLCD_M0_POS] && sh_new[`MLCD_M2_POS];
	assign line_write = bit_in && st_r.state == ST_DATA && st_r.cnt == `MLCD_DATA_LAST
		&& st_r.addr >= `MLCD_FIRST_LINE && st_r.addr <= `MLCD_LAST_LINE;
	assign wr_idx = `MLCD_LINE_W'(st_r.addr - `MLCD_FIRST_LINE);

	// Frame parser, memory writes, COM control and registered pixel view.
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_d = sclk_s;
		st_nxt.sel_d = sel_s;
		st_nxt.tog_d = tog_s;
		st_nxt.busy = sel_s;
		if (!sel_s) begin
			st_nxt.state = ST_IDLE; // Partial frames are dropped on deselect.
		end else if (!st_r.sel_d) begin
			st_nxt.state = ST_MODE;
			st_nxt.cnt = `MLCD_CNT_ZERO;
		end else if (bit_in) begin
			st_nxt.sh = sh_new;
			st_nxt.cnt = st_r.cnt + `MLCD_CNT_ONE;
			case (st_r.state)
				ST_MODE: begin
					if (st_r.cnt == `MLCD_MODE_LAST) begin
						st_nxt.cnt = `MLCD_CNT_ZERO;
						// Update mode walks lines; other modes skip line data and keep memory unless clearing.
						st_nxt.state = sh_new[`MLCD_M0_POS] ? ST_ADDR : ST_SKIP;
					end
				end
				ST_ADDR: begin
					if (st_r.cnt == `MLCD_ADDR_LAST) begin
						st_nxt.cnt = `MLCD_CNT_ZERO;
						st_nxt.addr = sh_new[`MLCD_ADDR_W-1:0];
						st_nxt.state = ST_DATA;
					end
				end
				ST_DATA: begin
					if (st_r.cnt == `MLCD_DATA_LAST) begin
						st_nxt.cnt = `MLCD_CNT_ZERO;
						st_nxt.state = ST_PAD;
					end
				end
				ST_PAD: begin
					if (st_r.cnt == `MLCD_PAD_LAST) begin
						st_nxt.cnt = `MLCD_CNT_ZERO;
						st_nxt.state = ST_ADDR;
					end
				end
				default: begin
					st_nxt.cnt = `MLCD_CNT_ZERO;
				end
			endcase
		end
		// Only the addressed line is replaced; all others hold.
		if (line_write) begin
			st_nxt.mem[wr_idx] = sh_new;
		end
		if (clear_go) begin
			st_nxt.mem = ALL_WHITE;
		end
		// COM moves only while the display is on.
		if (display_on_off_s) begin
			if (strap_s) begin
				if (tog_rise) begin
					st_nxt.com = !st_r.com;
				end
			end else if (mode_done) begin
				st_nxt.com = sh_new[`MLCD_M1_POS];
			end
		end
		// Blanking touches the view only, never the memory.
		if (display_on_off_s && PIX_LINE <= `MLCD_LAST_COL && PIX_COL <= `MLCD_LAST_COL) begin
			st_nxt.pix = st_r.mem[PIX_LINE][`MLCD_LAST_COL - PIX_COL];
		end else begin
			st_nxt.pix = `MLCD_WHITE;
		end
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_r <= '0;
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	assign PIXEL_SHOWN = st_r.pix;
	assign COMMON_ELECTRODE_LEVEL = st_r.com;
	assign FRAME_ACTIVE = st_r.busy;

	// ============================================================
	// Assertions
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);

	// Checks on the view port and blanking.
	blank_white_a: assert property (CE && !display_on_off_s |=> PIXEL_SHOWN == `MLCD_WHITE)
		else $error("pixel not white while display off");
	show_mem_a: assert property (CE && display_on_off_s && PIX_LINE <= `MLCD_LAST_COL
		&& PIX_COL <= `MLCD_LAST_COL |=> PIXEL_SHOWN ==
		$past(st_r.mem[PIX_LINE][`MLCD_LAST_COL - PIX_COL]))
		else $error("shown pixel differs from memory");

	// Checks on COM control.
	off_hold_a: assert property (!display_on_off_s |=> $stable(COMMON_ELECTRODE_LEVEL))
		else $error("COM changed while display off");
	ext_toggle_a: assert property (CE && display_on_off_s && strap_s && tog_rise
		|=> COMMON_ELECTRODE_LEVEL != $past(COMMON_ELECTRODE_LEVEL))
		else $error("COM did not follow external toggle");
	ext_ignored_a: assert property (!strap_s && !mode_done |=> $stable(COMMON_ELECTRODE_LEVEL))
		else $error("COM moved without serial flag");
	// The invert flag is the second mode bit, one place below the mode flag.
	flag_level_a: assert property (CE && display_on_off_s && !strap_s && mode_done
		|=> COMMON_ELECTRODE_LEVEL == $past(sh_new[`MLCD_M1_POS]))
		else $error("COM does not match frame invert flag");

	// Checks on the pixel memory and the frame parser.
	clear_all_a: assert property (CE && clear_go |=> st_r.mem == ALL_WHITE)
		else $error("memory not cleared to white");
	line_write_a: assert property (CE && line_write
		|=> st_r.mem[$past(wr_idx)] == $past(sh_new))
		else $error("line write lost");
	mem_keep_a: assert property (!line_write && !clear_go |=> $stable(st_r.mem))
		else $error("memory changed without a write");
	skip_mode_a: assert property (CE && mode_done && !sh_new[`MLCD_M0_POS]
		|=> st_r.state == ST_SKIP)
		else $error("display mode frame did not skip line data");
	frame_drop_a: assert property (CE && !sel_s |=> st_r.state == ST_IDLE && !FRAME_ACTIVE)
		else $error("frame kept running after deselect");

	// Main scenarios seen.
	clear_seen_c: cover property (CE && clear_go);
	line_seen_c: cover property (CE && line_write ##[1:300] CE && line_write);
	toggle_seen_c: cover property (CE && display_on_off_s && strap_s && tog_rise);
	blank_seen_c: cover property (display_on_off_s ##1 !display_on_off_s);
	flag_seen_c: cover property (CE && display_on_off_s && !strap_s && mode_done);

endmodule : memlcd_panel

`default_nettype wire

/* verification/serial_host.sv */
// Host model: drives the panel's serial clock, data and select pins.
// Assumes clk is the 10 MHz bench clock; one link bit takes 800 ns.
`timescale 1ns/10ps
`default_nettype none

module serial_host (
	// Bench clock
	input wire logic clk,
	// Serial link pins
	output logic sclk,
	output logic si,
	output logic sel
);
	// ============================================================
	// Link idles with its clock stopped and select low.
	initial begin
		sclk = 1'b0;
		si = 1'b0;
		sel = 1'b0;
	end

	// One bit: data set while the clock is low, then 400 ns high.
	task automatic put_bit(input logic b);
		si <= b;
		sclk <= 1'b0;
		repeat (4) @(posedge clk);
		sclk <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : put_bit

	// Select raised with the link clock parked low, well ahead of the first bit.
	task automatic open_frame;
		sel <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : open_frame

	// Clock parked low, released data inverted so it cannot look held, select dropped.
	task automatic close_frame;
		sclk <= 1'b0;
		si <= ~si;
		repeat (8) @(posedge clk);
		sel <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : close_frame

	// Whole frame: mode byte, one line if updating, then dummy bits.
	task automatic send_frame(input logic [7:0] mode, input logic [7:0] addr,
		input logic [95:0] data);
		open_frame();
		for (int i = 7; i >= 0; i--)
			put_bit(mode[i]);
		if (mode[7]) begin
			for (int i = 7; i >= 0; i--)
				put_bit(addr[i]);
			for (int i = 0; i < 96; i++)
				put_bit(data[i]);
		end
		for (int i = 0; i < 8; i++)
			put_bit(1'b0);
		close_frame();
	endtask : send_frame
endmodule : serial_host
`default_nettype wire

/* verification/tb_memlcd_panel.sv */
// Self-checking bench for the memory display panel.
// Assumes the host model drives the link; CE is held high except while the blanking test freezes it.
`timescale 1ns/10ps
`default_nettype none
`include "memlcd_params.svh"

module tb_memlcd_panel;
	import memlcd_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic tog = 1'b0;
	logic display_on_off = 1'b0;
	logic strap = 1'b0;
	logic ce = 1'b1;
	logic [`MLCD_LINE_W-1:0] pline = 7'h00;
	logic [`MLCD_LINE_W-1:0] pcol = 7'h00;
	logic [95:0] pat = {24{4'hA}};
	wire logic sclk;
	wire logic si;
	wire logic sel;
	wire logic shown;
	wire logic com;
	wire logic busy;
	// Thirty microseconds of 100 ns cycles, exactly 300.
	localparam int WAIT_30US = 300;
	int failures = 0;
	int num_checks = 0;

	// ============================================================
	// Clock, host model and the block itself.
	always #50 mclk = ~mclk;
	serial_host host (.clk(mclk), .sclk(sclk), .si(si), .sel(sel));
	memlcd_panel dut (.MCLK(mclk), .ARST_N(arst_n), .CE(ce), .SCLK(sclk), .SI(si),
		.SERIAL_SELECT_IN(sel), .EXT_INVERSION_TOGGLE(tog), .DISPLAY_ON_OFF(display_on_off),
		.INVERSION_SOURCE_STRAP(strap), .PIX_LINE(pline), .PIX_COL(pcol),
		.PIXEL_SHOWN(shown), .COMMON_ELECTRODE_LEVEL(com), .FRAME_ACTIVE(busy));

	// ============================================================
	// Comparison, pixel view and verdict helpers.
	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic see(input int ln, input int col, input logic exp);
		pline <= 7'(ln);
		pcol <= 7'(col);
		repeat (2) @(posedge mclk);
		chk(shown, exp);
	endtask : see

	task automatic line_is(input int ln, input logic [95:0] d);
		for (int c = 0; c < 96; c++)
			see(ln, c, d[c]);
	endtask : line_is

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// ============================================================
	// Scenarios.
	// Power-up: clear memory, let the latch settle, then raise display and toggle.
	task automatic t_power;
		host.send_frame(8'h20, 8'h00, '0);
		repeat (WAIT_30US) @(posedge mclk);
		display_on_off <= 1'b1;
		tog <= 1'b1;
		repeat (WAIT_30US) @(posedge mclk);
		chk(com, 1'b0);
		see(0, 0, 1'b1);
		$display("test power done");
	endtask : t_power

	// Line writes, then a frame cut before any bit, which must change nothing.
	task automatic t_write;
		host.send_frame(8'h80, 8'h05, pat);
		line_is(4, pat);
		host.send_frame(8'h80, 8'h60, ~pat);
		line_is(95, ~pat);
		line_is(4, pat);
		see(3, 1, 1'b1);
		host.open_frame();
		chk(busy, 1'b1);
		host.close_frame();
		chk(busy, 1'b0);
		see(4, 1, pat[1]);
		$display("test write done");
	endtask : t_write

	// Blanking, first under a frozen clock enable, then for real.
	task automatic t_blank;
		see(4, 1, pat[1]);
		ce <= 1'b0;
		display_on_off <= 1'b0;
		repeat (6) @(posedge mclk);
		chk(shown, pat[1]);
		ce <= 1'b1;
		repeat (6) @(posedge mclk);
		chk(shown, 1'b1);
		see(4, 0, 1'b1);
		display_on_off <= 1'b1;
		repeat (6) @(posedge mclk);
		line_is(4, pat);
		$display("test blank done");
	endtask : t_blank

	// Serial flag mode: flag sets COM, toggle pin ignored, display mode keeps memory.
	task automatic t_flag;
		host.send_frame(8'h40, 8'h00, '0);
		chk(com, 1'b1);
		see(4, 1, pat[1]);
		tog <= 1'b0;
		repeat (8) @(posedge mclk);
		tog <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(com, 1'b1);
		host.send_frame(8'h00, 8'h00, '0);
		chk(com, 1'b0);
		host.send_frame(8'h20, 8'h00, '0);
		see(4, 0, 1'b1);
		see(95, 1, 1'b1);
		$display("test flag done");
	endtask : t_flag

	// Strap moves only under reset, as on a board strapped anew and powered again.
	// The toggle pin stays high across the reset and must not count as a rise.
	task automatic t_toggle;
		arst_n <= 1'b0;
		strap <= 1'b1;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		chk(com, 1'b0);
		see(4, 0, 1'b0);
		tog <= 1'b0;
		repeat (8) @(posedge mclk);
		tog <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(com, 1'b1);
		tog <= 1'b0;
		repeat (8) @(posedge mclk);
		chk(com, 1'b1);
		display_on_off <= 1'b0;
		tog <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(com, 1'b1);
		$display("test toggle done");
	endtask : t_toggle

	// Main sequence after a three-cycle reset.
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_power();
		t_write();
		t_blank();
		t_flag();
		t_toggle();
		wrap_up();
	end

	// Watchdog against a hung run.
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		wrap_up();
	end
endmodule : tb_memlcd_panel
`default_nettype wire
